// File: shared/rx_video_pass_qualifier_consts.vh
// Purpose: constants for the receive-port video pass qualifier
// Assumes: one 250 MHz clock, byte-wide video beats from the link receiver
// Notes: offsets are register indices on the local register port
`ifndef RX_VIDEO_PASS_QUALIFIER_CONSTS_VH
`define RX_VIDEO_PASS_QUALIFIER_CONSTS_VH

// Register indices
`define ADDR_TRUNC_CFG 8'h7C
`define ADDR_PASS_CTL 8'h7D
`define ADDR_PASS_STATUS 8'h7E
`define TRUNC_CFG_RESET 8'h00
`define PASS_CTL_RESET 8'h00

// Truncation configuration fields
`define TRUNC_LINE_SIZE_BIT 0
`define TRUNC_LINE_CNT_BIT 1
`define TRUNC_PARITY_BIT 2

// Pass control fields
`define THRESH_LSB 0
`define THRESH_MSB 1
`define QUAL_PARITY_BIT 2
`define QUAL_LINE_SIZE_BIT 3
`define QUAL_LINE_CNT_BIT 4
`define DISCARD_EN_BIT 7

// Status fields
`define STS_PASS_BIT 0
`define STS_LOCK_BIT 1
`define STS_LEN_UNSTABLE_BIT 2
`define STS_CNT_CHANGE_BIT 3
`define STS_TRUNCATED_BIT 4
`define STS_PASS_LOST_BIT 5

// Buffer geometry and beat word layout
`define BEAT_WIDTH 11
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FIFO_STALL_LEVEL 5'h0C
`define WORD_SOF_BIT 10
`define WORD_EOL_BIT 9
`define WORD_EOF_BIT 8
`define SIZE_WIDTH 16

`endif

// File: core/rx_video_pass_qualifier.v
// Purpose: qualify received video, gate and truncate frames toward the video buffer
// Assumes: all inputs come from logic on clk_sys; one byte per beat
// Notes: a 16-word FIFO sits between the gate and the buffer side
`timescale 1ns/10ps
`default_nettype none
`include "rx_video_pass_qualifier_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Buffer between the gate and the internal video buffer
module video_fifo #(
   parameter WIDTH = 11,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire reset_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire push;
   wire pop;

   // Extra pointer bit tells full from empty
   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != DEPTH[AW:0]) ? 1'b1 : 1'b0;
   assign out_valid = (level != {(AW+1){1'b0}}) ? 1'b1 : 1'b0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointer update
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage needs no reset, contents guarded by level
   always @(posedge clk_sys) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rx_video_pass_qualifier (
   input wire clk_sys,
   input wire reset_n,
   input wire lock,
   input wire link_parity_err,
   input wire csi_parity_err,
   input wire in_valid,
   output reg in_ready,
   input wire [7:0] in_data,
   input wire in_sof,
   input wire in_eol,
   input wire in_eof,
   output reg out_valid,
   input wire out_ready,
   output reg [7:0] out_data,
   output reg out_sof,
   output reg out_eol,
   output reg out_eof,
   output reg pass,
   output reg pass_deassert_flag,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata
);
   reg [7:0] port_error_truncation_config;
   reg [7:0] port_pass_qualification_control;
   reg [`SIZE_WIDTH-1:0] cur_len;
   reg [`SIZE_WIDTH-1:0] len_ref;
   reg len_ref_ok;
   reg [`SIZE_WIDTH-1:0] line_cnt;
   reg [`SIZE_WIDTH-1:0] lines_ref;
   reg lines_ref_ok;
   reg in_frame;
   reg frame_bad;
   reg fwd;
   reg blocked;
   reg [1:0] valid_cnt;
   reg len_unstable;
   reg cnt_change;
   reg truncated;
   reg stg_valid;
   reg [`BEAT_WIDTH-1:0] stg_word;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [`BEAT_WIDTH-1:0] fifo_out_data;
   wire [`FIFO_AW:0] fifo_level;

   // Control fields
   wire [1:0] qualify_frame_count = port_pass_qualification_control[`THRESH_MSB:`THRESH_LSB];
   wire q_parity = port_pass_qualification_control[`QUAL_PARITY_BIT];
   wire q_line_size = port_pass_qualification_control[`QUAL_LINE_SIZE_BIT];
   wire qualify_on_line_count = port_pass_qualification_control[`QUAL_LINE_CNT_BIT];
   wire discard_en = port_pass_qualification_control[`DISCARD_EN_BIT];
   wire t_line_size = port_error_truncation_config[`TRUNC_LINE_SIZE_BIT];
   wire t_line_cnt = port_error_truncation_config[`TRUNC_LINE_CNT_BIT];
   wire t_parity = port_error_truncation_config[`TRUNC_PARITY_BIT];
   wire beat = in_valid && in_ready;

   reg [`SIZE_WIDTH-1:0] meas_len;
   reg [`SIZE_WIDTH-1:0] meas_lines;
   reg len_mis;
   reg cnt_chg;
   reg restart;
   reg eof_ok;
   reg fwd_cur;
   reg trunc_hit;
   reg take_beat;
   reg [1:0] eff_thresh;
   reg [1:0] next_valid_cnt;
   reg next_pass;

   ////////////////////////////////////////////////////////////////////////////
   // Measurement and qualification decisions for this cycle
   always @* begin
      meas_len = (in_sof ? {`SIZE_WIDTH{1'b0}} : cur_len) + 1'b1;
      meas_lines = (in_sof ? {`SIZE_WIDTH{1'b0}} : line_cnt) + 1'b1;
      // Every line must match the reference length
      len_mis = beat && in_eol && len_ref_ok && (meas_len != len_ref);
      // Too many lines seen early, or wrong total at frame end
      cnt_chg = beat && in_eol && lines_ref_ok &&
         ((meas_lines > lines_ref) || (in_eof && (meas_lines != lines_ref)));
      // Any failed enabled qualification restarts counting
      restart = !lock || (q_line_size && len_mis) || (qualify_on_line_count && cnt_chg) ||
         (q_parity && link_parity_err);
      eof_ok = beat && in_eof && (in_frame || in_sof) && !frame_bad && !restart;
      // Saturating valid frame counter
      if (restart) begin
         next_valid_cnt = 2'h0;
      end else if (eof_ok && (valid_cnt < qualify_frame_count)) begin
         next_valid_cnt = valid_cnt + 2'h1;
      end else begin
         next_valid_cnt = valid_cnt;
      end
      // Parity qualification lowers the bar by one frame
      if (qualify_frame_count == 2'h0) begin
         eff_thresh = 2'h0;
      end else begin
         eff_thresh = qualify_frame_count - {1'b0, q_parity};
      end
      next_pass = lock && (next_valid_cnt >= eff_thresh);
      // Forwarding only starts on a frame start
      if (beat && in_sof) begin
         fwd_cur = !blocked && !(discard_en && !pass);
      end else begin
         fwd_cur = fwd;
      end
      // Cut the frame wherever the error shows up
      trunc_hit = fwd_cur && ((t_line_size && len_mis) || (t_line_cnt && cnt_chg) ||
         (t_parity && csi_parity_err));
      take_beat = beat && fwd_cur && !trunc_hit && !(discard_en && !pass);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line and frame size tracking
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cur_len <= {`SIZE_WIDTH{1'b0}};
         len_ref <= {`SIZE_WIDTH{1'b0}};
         len_ref_ok <= 1'b0;
         line_cnt <= {`SIZE_WIDTH{1'b0}};
         lines_ref <= {`SIZE_WIDTH{1'b0}};
         lines_ref_ok <= 1'b0;
         in_frame <= 1'b0;
         frame_bad <= 1'b0;
      end else if (!lock) begin
         // New lock, new references
         len_ref_ok <= 1'b0;
         lines_ref_ok <= 1'b0;
         in_frame <= 1'b0;
         frame_bad <= 1'b0;
      end else if (beat) begin
         cur_len <= in_eol ? {`SIZE_WIDTH{1'b0}} : meas_len;
         if (in_eol) begin
            // Adopt a changed length so the next line is judged on it
            len_ref <= meas_len;
            len_ref_ok <= 1'b1;
            line_cnt <= meas_lines;
         end else if (in_sof) begin
            line_cnt <= {`SIZE_WIDTH{1'b0}};
         end
         if (in_eof) begin
            lines_ref <= meas_lines;
            lines_ref_ok <= 1'b1;
            line_cnt <= {`SIZE_WIDTH{1'b0}};
         end
         in_frame <= !in_eof;
         // A frame cut before its end beat never counts as valid, so it cannot lift the block
         frame_bad <= (in_eof ? 1'b0 : ((in_sof ? 1'b0 : frame_bad) || restart || trunc_hit));
      end else if (restart || trunc_hit) begin
         frame_bad <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pass state, forwarding gate and stage toward the FIFO
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         valid_cnt <= 2'h0;
         pass <= 1'b0;
         fwd <= 1'b0;
         blocked <= 1'b0;
         stg_valid <= 1'b0;
         stg_word <= {`BEAT_WIDTH{1'b0}};
         in_ready <= 1'b0;
      end else begin
         valid_cnt <= next_valid_cnt;
         pass <= next_pass;
         // Back-pressure margin covers two beats in flight
         in_ready <= fifo_in_ready && (fifo_level < `FIFO_STALL_LEVEL);
         if (trunc_hit) begin
            fwd <= 1'b0;
            blocked <= 1'b1;
         end else if (beat) begin
            fwd <= take_beat && !in_eof;
            if (eof_ok) blocked <= 1'b0;
         end else if (discard_en && !pass) begin
            fwd <= 1'b0;
         end
         stg_valid <= take_beat;
         stg_word <= {in_sof, in_eol, in_eof, in_data};
      end
   end

   video_fifo #(
      .WIDTH(`BEAT_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) video_fifo_i (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .in_valid(stg_valid),
      .in_ready(fifo_in_ready),
      .in_data(stg_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   assign fifo_out_ready = !out_valid || out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Registered output toward the video buffer
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_sof <= 1'b0;
         out_eol <= 1'b0;
         out_eof <= 1'b0;
      end else if (fifo_out_ready) begin
         out_valid <= fifo_out_valid;
         out_data <= fifo_out_data[7:0];
         out_sof <= fifo_out_data[`WORD_SOF_BIT];
         out_eol <= fifo_out_data[`WORD_EOL_BIT];
         out_eof <= fifo_out_data[`WORD_EOF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port; sticky status clears on read, a new event wins
   wire rd_status = reg_read && (reg_addr == `ADDR_PASS_STATUS);
   wire pass_drop = pass && !next_pass;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         port_error_truncation_config <= `TRUNC_CFG_RESET;
         port_pass_qualification_control <= `PASS_CTL_RESET;
         len_unstable <= 1'b0;
         cnt_change <= 1'b0;
         truncated <= 1'b0;
         pass_deassert_flag <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         if (reg_write && (reg_addr == `ADDR_TRUNC_CFG)) begin
            port_error_truncation_config <= reg_wdata;
         end
         if (reg_write && (reg_addr == `ADDR_PASS_CTL)) begin
            port_pass_qualification_control <= reg_wdata;
         end
         len_unstable <= len_mis || (len_unstable && !rd_status);
         cnt_change <= cnt_chg || (cnt_change && !rd_status);
         truncated <= trunc_hit || (truncated && !rd_status);
         pass_deassert_flag <= pass_drop || (pass_deassert_flag && !rd_status);
         if (reg_read) begin
            case (reg_addr)
               `ADDR_TRUNC_CFG: begin
                  reg_rdata <= port_error_truncation_config;
               end
               `ADDR_PASS_CTL: begin
                  reg_rdata <= port_pass_qualification_control;
               end
               `ADDR_PASS_STATUS: begin
                  reg_rdata <= {2'b00, pass_deassert_flag, truncated, cnt_change,
                     len_unstable, lock, pass};
               end
               default: begin
                  reg_rdata <= 8'h00;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/rx_video_pass_qualifier_assertions.sv
// Purpose: port checks for the video pass qualifier
// Assumes: one clock, shadows follow the register write strobe
// Notes: shadows let pass rules be judged from ports alone
`timescale 1ns/10ps
`default_nettype none
`include "rx_video_pass_qualifier_consts.vh"
module rx_video_pass_qualifier_assertions (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic lock,
   input wire logic link_parity_err,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic in_eof,
   input wire logic pass,
   input wire logic pass_deassert_flag,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata
);
   logic [7:0] ctl;
   logic [7:0] cfg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // Shadows, so pass rules see the live control fields
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctl <= 8'h00;
         cfg <= 8'h00;
      end else if (reg_write) begin
         if (reg_addr == `ADDR_PASS_CTL) ctl <= reg_wdata;
         if (reg_addr == `ADDR_TRUNC_CFG) cfg <= reg_wdata;
      end
   end
   fall_sets_flag_a: assert property ($fell(pass) |-> ##[0:1] pass_deassert_flag)
      else $error("pass fell without flag");
   lock_loss_drop_a: assert property (!lock |=> !pass)
      else $error("pass held without lock");
   parity_drop_a: assert property ((link_parity_err && ctl[`QUAL_PARITY_BIT]) |=> !pass)
      else $error("pass held after parity error");
   thresh_zero_a: assert property ((lock && ctl[4:0] == 5'h00 && !reg_write) |=> pass)
      else $error("no pass on lock");
   eof_raise_a: assert property (($rose(pass) && ctl[1:0] > {1'b0, ctl[2]})
      |-> $past(in_valid && in_ready && in_eof)) else $error("pass rose off frame end");
   ctl_readback_a: assert property ((reg_read && !reg_write && reg_addr == `ADDR_PASS_CTL)
      |=> reg_rdata == ctl) else $error("control readback differs");
   cfg_readback_a: assert property ((reg_read && !reg_write && reg_addr == `ADDR_TRUNC_CFG)
      |=> reg_rdata == cfg) else $error("config readback differs");
   status_live_a: assert property ((reg_read && reg_addr == `ADDR_PASS_STATUS)
      |=> reg_rdata[1:0] == {$past(lock), $past(pass)}) else $error("status bits stale");
endmodule
`default_nettype wire

// File: dv/video_source_model.sv
// Purpose: remote sensor link model sending byte frames
// Assumes: caller starts a frame just after a rising edge
// Notes: idle data is inverted so stale bytes never look valid
`timescale 1ns/10ps
`default_nettype none
module video_source_model (
   input wire logic clk_sys,
   input wire logic in_ready,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic in_sof,
   output logic in_eol,
   output logic in_eof
);
   ////////////////////////////////////////
   // Quiet link at time zero
   initial begin
      in_valid = 1'b0;
      in_data = 8'h00;
      in_sof = 1'b0;
      in_eol = 1'b0;
      in_eof = 1'b0;
   end
   // Line "bad" is one byte short; gap gives a slow sender
   task automatic send_frame(input int lines, input int len, input int bad, input int gap);
      int n;
      for (int l = 0; l < lines; l++) begin
         n = (l == bad) ? len - 1 : len;
         for (int b = 0; b < n; b++) begin
            in_valid <= 1'b1;
            in_data <= 8'(l * 16 + b);
            in_sof <= (l == 0 && b == 0);
            in_eol <= (b == n - 1);
            in_eof <= (l == lines - 1 && b == n - 1);
            do @(posedge clk_sys); while (!in_ready);
            if (gap > 0) begin
               in_valid <= 1'b0;
               in_data <= ~in_data;
               repeat (gap) @(posedge clk_sys);
            end
         end
      end
      in_valid <= 1'b0;
      in_eof <= 1'b0;
      in_data <= ~in_data;
   endtask
endmodule
`default_nettype wire

// File: dv/rx_video_pass_qualifier_bench.sv
// Purpose: scenario bench for the video pass qualifier
// Assumes: 250 MHz clock, register strobes one cycle
// Notes: out beats are tallied by a monitor, checks use deltas
`timescale 1ns/10ps
`default_nettype none
module rx_video_pass_qualifier_bench;
   logic clk_sys, reset_n, lock, link_parity_err, csi_parity_err, pass, pass_deassert_flag;
   logic in_valid, in_ready, in_sof, in_eol, in_eof, out_valid, out_ready, out_sof, out_eol, out_eof;
   logic reg_write, reg_read;
   logic [7:0] in_data, out_data, reg_addr, reg_wdata, reg_rdata, v;
   int err_total, check_count, n_beat, n_sof, n_eof, b0, e0, s0;
   rx_video_pass_qualifier rx_video_pass_qualifier_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .lock(lock), .link_parity_err(link_parity_err), .csi_parity_err(csi_parity_err),
      .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sof(in_sof),
      .in_eol(in_eol), .in_eof(in_eof), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol), .out_eof(out_eof),
      .pass(pass), .pass_deassert_flag(pass_deassert_flag), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   video_source_model video_source_model_i (.clk_sys(clk_sys), .in_ready(in_ready),
      .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof), .in_eol(in_eol), .in_eof(in_eof));
   ////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   // Data lands on the edge that takes the read
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(posedge clk_sys);
      v = reg_rdata;
   endtask
   // Dropping lock restarts qualification from zero
   task relock;
      lock <= 1'b0;
      repeat (3) @(posedge clk_sys);
      lock <= 1'b1;
      @(posedge clk_sys);
   endtask
   task frame(input int bad, input int gap);
      b0 = n_beat;
      e0 = n_eof;
      s0 = n_sof;
      video_source_model_i.send_frame(3, 6, bad, gap);
      repeat (20) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////
   task t_regs;
      rd(8'h7C);
      check(v, 8'h00);
      rd(8'h7D);
      check(v, 8'h00);
      rd(8'h00);
      check(v, 8'h00);
   endtask
   task t_lock;
      lock <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(pass, 1'b1);
      lock <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(pass, 1'b0);
      check(pass_deassert_flag, 1'b1);
      rd(8'h7E);
      check(v[5], 1'b1);
      check(pass_deassert_flag, 1'b0);
   endtask
   task t_thresh;
      wr(8'h7D, 8'h02);
      relock();
      frame(9, 0);
      check(pass, 1'b0);
      frame(9, 1);
      check(pass, 1'b1);
   endtask
   task t_trunc;
      wr(8'h7D, 8'h1A);
      wr(8'h7C, 8'h01);
      frame(9, 0);
      check(n_eof - e0, 1);
      frame(1, 0);
      check(n_eof - e0, 0);
      check(n_beat - b0 >= 6, 1'b1);
      rd(8'h7E);
      check(v[4], 1'b1);
      check(v[2], 1'b1);
      frame(9, 0);
      check(n_eof - e0, 0);
      frame(9, 0);
      check(n_sof - s0, 1);
      check(n_eof - e0, 1);
      video_source_model_i.send_frame(4, 6, 9, 0);
      rd(8'h7E);
      check(v[3], 1'b1);
      check(pass, 1'b0);
   endtask
   task t_discard;
      wr(8'h7C, 8'h00);
      wr(8'h7D, 8'h82);
      relock();
      frame(9, 0);
      check(n_beat - b0, 0);
      frame(9, 0);
      check(pass, 1'b1);
      out_ready <= 1'b0;
      b0 = n_beat;
      fork
         video_source_model_i.send_frame(3, 6, 9, 0);
         begin
            repeat (40) @(posedge clk_sys);
            check(in_ready, 1'b0);
            out_ready <= 1'b1;
         end
      join
      repeat (20) @(posedge clk_sys);
      check(n_beat - b0, 18);
   endtask
   task t_parity;
      wr(8'h7D, 8'h06);
      relock();
      frame(9, 0);
      check(pass, 1'b1);
      link_parity_err <= 1'b1;
      @(posedge clk_sys);
      link_parity_err <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(pass, 1'b0);
   endtask
   // CSI parity cut mid-frame, then one dropped frame, then a fresh start
   task t_csi;
      wr(8'h7C, 8'h04);
      fork
         frame(9, 0);
         begin
            repeat (8) @(posedge clk_sys);
            csi_parity_err <= 1'b1;
            @(posedge clk_sys);
            csi_parity_err <= 1'b0;
         end
      join
      check(n_eof - e0, 0);
      check(n_beat - b0 < 18, 1'b1);
      rd(8'h7E);
      check(v[4], 1'b1);
      frame(9, 0);
      check(n_sof - s0, 0);
      frame(9, 0);
      check(n_sof - s0, 1);
      check(n_eof - e0, 1);
   endtask
   ////////////////////////////////////////
   // Output tally, sampled before the edge's updates
   always @(posedge clk_sys) begin
      if (out_valid && out_ready) begin
         n_beat++;
         n_sof += out_sof;
         n_eof += out_eof;
         if (out_sof) check(out_data, 8'h00);
         if (out_eof) check(out_eol, 1'b1);
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Whole run needs well under 25000 cycles
   initial begin
      #100000;
      err_total++;
      print_verdict();
   end
   initial begin
      {reset_n, lock, link_parity_err, csi_parity_err, reg_write, reg_read} = 6'h00;
      {reg_addr, reg_wdata, out_ready} = {16'h0000, 1'b1};
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_regs();
      t_lock();
      t_thresh();
      t_trunc();
      t_discard();
      t_parity();
      t_csi();
      print_verdict();
   end
endmodule
bind rx_video_pass_qualifier rx_video_pass_qualifier_assertions chk_i (.clk_sys(clk_sys),
   .reset_n(reset_n), .lock(lock), .link_parity_err(link_parity_err), .in_valid(in_valid),
   .in_ready(in_ready), .in_eof(in_eof), .pass(pass), .pass_deassert_flag(pass_deassert_flag),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata));
`default_nettype wire
